// [include/dlr_pkg.sv]
/*
 * Constants for the DDR leveling delay register bank: register offsets,
 * writable masks, field placement of each data group, bus encodings.
 * Assumes a 32-bit AHB-Lite slave port with 10 decoded address bits (11:2).
 */
package dlr_pkg;

   // ---------------------------------------------------------------------
   // Sizes
   // ---------------------------------------------------------------------
   localparam int N_GRP  = 9;
   localparam int N_RW   = 13;
   localparam int N_VIEW = 18;
   localparam int FW     = 16;

   typedef logic [11:0] dlr_off_t;

   // ---------------------------------------------------------------------
   // Register map, rows 0..12 writable, 13..17 read only
   // ---------------------------------------------------------------------
   localparam dlr_off_t VIEW_OFF [N_VIEW] = '{
      12'ha90, 12'haa0, 12'had0, 12'hae0, 12'haf0, 12'hb00, 12'hb10,
      12'hc00, 12'hc10, 12'hc20, 12'hc30, 12'hc40, 12'hc50,
      12'hab0, 12'hac0, 12'hc60, 12'hc70, 12'hc80};

   localparam logic [63:0] M_ALL = 64'hffff_ffff_ffff_ffff;
   localparam logic [63:0] M_LO  = 64'h0000_0000_0000_ffff;
   localparam logic [63:0] RW_MASK [N_RW] = '{
      M_ALL, 64'h0000_ffff_ffff_ffff, M_ALL, M_ALL, M_ALL, M_ALL, M_ALL,
      M_ALL, M_LO, M_ALL, M_ALL, M_LO, 64'h0000_0000_0000_0001};
   localparam logic [63:0] RW_RESET = 64'h0000_0000_0000_0000;

   // Rows holding single fields, and their 16-bit lanes
   localparam int ROW_LIMITS   = 1;
   localparam int LANE_GMAX    = 0;
   localparam int LANE_GREFR   = 1;
   localparam int LANE_RMAX    = 2;
   localparam int ROW_RREFR    = 4;
   localparam int LANE_RREFR   = 1;
   localparam int ROW_WREFR    = 6;
   localparam int LANE_WREFR   = 3;
   localparam int ROW_CTRL     = 12;
   localparam int BIT_HW_LVL   = 0;
   localparam int V_MID_1_4    = 13;
   localparam int V_MID_5_8    = 14;
   localparam int V_END_0_3    = 15;
   localparam int V_END_4_7    = 16;
   localparam int V_END_8      = 17;

   // ---------------------------------------------------------------------
   // Per-group placement: row and lane of each group's field
   // ---------------------------------------------------------------------
   localparam int GATE_ROW  [N_GRP] = '{7, 7, 7, 7, 8, 0, 0, 0, 0};
   localparam int GATE_LANE [N_GRP] = '{0, 1, 2, 3, 0, 0, 1, 2, 3};
   localparam int OFFS_ROW  [N_GRP] = '{2, 2, 2, 2, 3, 3, 3, 3, 4};
   localparam int OFFS_LANE [N_GRP] = '{0, 1, 2, 3, 0, 1, 2, 3, 0};
   localparam int WR_ROW    [N_GRP] = '{4, 4, 5, 5, 5, 5, 6, 6, 6};
   localparam int WR_LANE   [N_GRP] = '{2, 3, 0, 1, 2, 3, 0, 1, 2};
   localparam int RDLY_ROW  [N_GRP] = '{9, 9, 9, 9, 10, 10, 10, 10, 11};
   localparam int RDLY_LANE [N_GRP] = '{0, 1, 2, 3, 0, 1, 2, 3, 0};

   // ---------------------------------------------------------------------
   // Bus encodings
   // ---------------------------------------------------------------------
   localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
   localparam logic       HRESP_OKAY    = 1'h0;

   typedef enum logic [1:0] {ST_IDLE, ST_WRITE, ST_RD_WAIT, ST_RD_DATA}
      dlr_state_t;

endpackage : dlr_pkg

// [verilog/dlr_leveling_regs.sv]
/*
 * DDR leveling delay register bank: gate, read, center-offset and write
 * strobe delays for nine data groups, search limits, retrain intervals,
 * captured leveling windows and the read-only center points.
 * Assumes an AHB-Lite master on REF_CLK and a leveling engine that
 * reports each group's begin/end window with a one-cycle strobe.
 * Assumes whole-word accesses only; HSIZE is not decoded, so a narrow
 * write still stores the whole 32-bit word.
 * Assumes the PHY takes every delay output as a level in this clock
 * domain; none of them is synchronised here.
 * Assumes software leaves the retrain intervals at zero.
 */
// How it works
// - Each group 0..8 holds a 16-bit gate sampling delay.
// - With hardware read leveling on, center is middle of begin/end.
// - Otherwise center mirrors programmed read delay; center is read only.
// - Read-leveling search limit is a 16-bit field at bits 47:32.
// - Gate-training search limit is a 16-bit field at bits 15:0.
// - 16-bit refresh count between automatic gate trainings; set zero.
// - 16-bit refresh count between automatic read levelings; set zero.
// - Each group adds a 16-bit offset to its center for capture.
// - Each group's write strobe DLL delay comes from its 16-bit field.
// - Each group records a 16-bit end delay of the leveling window.
`timescale 1ns/1ps

module dlr_leveling_regs (
   input  wire logic                REF_CLK,
   input  wire logic                RESET_N,
   // AHB-Lite slave
   input  wire logic                HSEL,
   input  wire logic [31:0]         HADDR,
   input  wire logic [1:0]          HTRANS,
   input  wire logic                HWRITE,
   input  wire logic [2:0]          HSIZE,
   input  wire logic [31:0]         HWDATA,
   input  wire logic                HREADY,
   output logic                     HREADYOUT,
   output logic [31:0]              HRDATA,
   output logic                     HRESP,
   // Leveling engine results
   input  wire logic                LVL_RESULT_STB,
   input  wire logic [3:0]          LVL_RESULT_GROUP,
   input  wire logic [15:0]         LVL_BEGIN_DELAY,
   input  wire logic [15:0]         LVL_END_DELAY,
   // Delay settings toward the PHY, group g in bits 16*g +: 16
   output logic [143:0]             GATE_DELAY,
   output logic [143:0]             RD_CAPTURE_DELAY,
   output logic [143:0]             WR_DQS_DELAY,
   output logic [15:0]              GATE_MAX_DELAY,
   output logic [15:0]              RDLVL_MAX_DELAY,
   output logic [15:0]              GATE_REFRESH_INTERVAL,
   output logic [15:0]              RDLVL_REFRESH_INTERVAL,
   output logic [15:0]              WRLVL_REFRESH_INTERVAL,
   output logic                     RDLVL_HW_ENABLE
);

   // ---------------------------------------------------------------------
   // Functions
   // ---------------------------------------------------------------------
   // Both words of a 64-bit row; upper address bits alias
   function automatic logic hit(input logic [11:0] a,
                                input logic [11:0] off);
      return a[11:3] == off[11:3];
   endfunction : hit

   // Results beyond a nonzero search limit are pulled back to it; a zero limit clamps nothing
   function automatic logic [15:0] clamp(input logic [15:0] v,
                                         input logic [15:0] lim);
      logic [15:0] r;
      r = v;
      if (lim != 16'h0000 && v > lim) begin
         r = lim;
      end
      return r;
   endfunction : clamp

   // One 16-bit field of a 64-bit row, lane 0 at the bottom
   function automatic logic [15:0] lane16(input logic [63:0] w,
                                          input int          l);
      return w[16*l +: 16];
   endfunction : lane16

   // ---------------------------------------------------------------------
   // Declarations
   // ---------------------------------------------------------------------
   // Bus side
   dlr_pkg::dlr_state_t state_reg;
   dlr_pkg::dlr_state_t state_next;
   logic [11:0]         addr_reg;
   logic [31:0]         hrdata_reg;

   // Register storage and the views software reads
   logic [63:0]         rw_reg   [dlr_pkg::N_RW];
   logic [63:0]         rw_next  [dlr_pkg::N_RW];
   logic [63:0]         view     [dlr_pkg::N_VIEW];
   logic [63:0]         read_train_limits_and_center_0;
   logic [63:0]         write_strobe_delay_and_retrain;
   logic [63:0]         write_strobe_groups_6_to_8;
   logic [63:0]         read_center_groups_1_to_4;
   logic [63:0]         read_center_groups_5_to_8;

   // Per-group values
   logic [15:0]         begin_reg[dlr_pkg::N_GRP];
   logic [15:0]         end_reg  [dlr_pkg::N_GRP];
   logic [15:0]         mid      [dlr_pkg::N_GRP];
   logic [15:0]         cap_reg  [dlr_pkg::N_GRP];
   logic [15:0]         rdly     [dlr_pkg::N_GRP];
   logic [15:0]         offs     [dlr_pkg::N_GRP];

   // Decode and single fields
   logic [31:0]         rd_word;
   logic                accept;
   logic                wr_commit;
   logic                rd_load;
   logic                hw_lvl;
   logic [15:0]         rd_max;

   // ---------------------------------------------------------------------
   // Bus handshake
   // ---------------------------------------------------------------------
   assign accept    = HSEL && HREADY && (HTRANS == dlr_pkg::HTRANS_NONSEQ);
   assign wr_commit = (state_reg == dlr_pkg::ST_WRITE);
   assign rd_load   = (state_reg == dlr_pkg::ST_RD_WAIT);
   assign HREADYOUT = (state_reg != dlr_pkg::ST_RD_WAIT);
   assign HRESP     = dlr_pkg::HRESP_OKAY;
   assign HRDATA    = hrdata_reg;

   // Read waits one cycle so a write just before it is already stored
   always_comb begin
      state_next = dlr_pkg::ST_IDLE;
      case (state_reg)
         dlr_pkg::ST_RD_WAIT: begin
            state_next = dlr_pkg::ST_RD_DATA;
         end
         dlr_pkg::ST_IDLE,
         dlr_pkg::ST_WRITE,
         dlr_pkg::ST_RD_DATA: begin
            if (accept) begin
               state_next = HWRITE ? dlr_pkg::ST_WRITE
                                   : dlr_pkg::ST_RD_WAIT;
            end
         end
         default: begin
            state_next = dlr_pkg::ST_IDLE;
         end
      endcase
   end

   always_ff @(posedge REF_CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         state_reg <= dlr_pkg::ST_IDLE;
      end else begin
         state_reg <= state_next;
      end
   end

   // Address kept for the data phase, which may overlap the next request
   always_ff @(posedge REF_CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         addr_reg <= 12'h000;
      end else if (accept) begin
         addr_reg <= HADDR[11:0];
      end
   end

   // Read data stands until the next read loads it
   always_ff @(posedge REF_CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         hrdata_reg <= 32'h0000_0000;
      end else if (rd_load) begin
         hrdata_reg <= rd_word;
      end
   end

   // ---------------------------------------------------------------------
   // Writable rows
   // ---------------------------------------------------------------------
   // Only whole-word writes; HSIZE is not checked
   generate
      for (genvar r = 0; r < dlr_pkg::N_RW; r++) begin : g_rw
         logic [63:0] merged;
         assign merged = addr_reg[2] ? {HWDATA, rw_reg[r][31:0]}
                                     : {rw_reg[r][63:32], HWDATA};
         // Read-only bits keep their value through the mask
         assign rw_next[r] = (rw_reg[r] & ~dlr_pkg::RW_MASK[r]) |
                             (merged & dlr_pkg::RW_MASK[r]);
         always_ff @(posedge REF_CLK or negedge RESET_N) begin
            if (!RESET_N) begin
               rw_reg[r] <= dlr_pkg::RW_RESET;
            end else if (wr_commit && hit(addr_reg, dlr_pkg::VIEW_OFF[r]))
            begin
               rw_reg[r] <= rw_next[r];
            end
         end
         // Group 0 center sits in the top lane of the limits row
         if (r == dlr_pkg::ROW_LIMITS) begin : g_mid0
            assign view[r] = {mid[0], rw_reg[r][47:0]};
         end else begin : g_plain
            assign view[r] = rw_reg[r];
         end
      end
   endgenerate

   // ---------------------------------------------------------------------
   // Named rows
   // ---------------------------------------------------------------------
   assign read_train_limits_and_center_0 = rw_reg[dlr_pkg::ROW_LIMITS];
   assign write_strobe_delay_and_retrain = rw_reg[dlr_pkg::ROW_RREFR];
   assign write_strobe_groups_6_to_8     = rw_reg[dlr_pkg::ROW_WREFR];

   // ---------------------------------------------------------------------
   // Single fields
   // ---------------------------------------------------------------------
   assign GATE_MAX_DELAY =
      lane16(read_train_limits_and_center_0, dlr_pkg::LANE_GMAX);
   assign rd_max =
      lane16(read_train_limits_and_center_0, dlr_pkg::LANE_RMAX);
   assign RDLVL_MAX_DELAY = rd_max;
   assign GATE_REFRESH_INTERVAL =
      lane16(read_train_limits_and_center_0, dlr_pkg::LANE_GREFR);
   assign RDLVL_REFRESH_INTERVAL =
      lane16(write_strobe_delay_and_retrain, dlr_pkg::LANE_RREFR);
   assign WRLVL_REFRESH_INTERVAL =
      lane16(write_strobe_groups_6_to_8, dlr_pkg::LANE_WREFR);
   assign hw_lvl = rw_reg[dlr_pkg::ROW_CTRL][dlr_pkg::BIT_HW_LVL];
   assign RDLVL_HW_ENABLE = hw_lvl;

   // ---------------------------------------------------------------------
   // Per-group logic
   // ---------------------------------------------------------------------
   generate
      for (genvar g = 0; g < dlr_pkg::N_GRP; g++) begin : g_grp
         logic [16:0] sum;
         logic        take;

         // Settings toward the PHY come straight from the rows
         assign GATE_DELAY[16*g +: 16] =
            rw_reg[dlr_pkg::GATE_ROW[g]][16*dlr_pkg::GATE_LANE[g] +: 16];
         assign WR_DQS_DELAY[16*g +: 16] =
            rw_reg[dlr_pkg::WR_ROW[g]][16*dlr_pkg::WR_LANE[g] +: 16];

         // Sources of the center point and of its offset
         assign rdly[g] =
            rw_reg[dlr_pkg::RDLY_ROW[g]][16*dlr_pkg::RDLY_LANE[g] +: 16];
         assign offs[g] =
            rw_reg[dlr_pkg::OFFS_ROW[g]][16*dlr_pkg::OFFS_LANE[g] +: 16];

         // Window from the engine, clamped to the search limit
         assign take = LVL_RESULT_STB && (LVL_RESULT_GROUP == 4'(g));
         always_ff @(posedge REF_CLK or negedge RESET_N) begin
            if (!RESET_N) begin
               begin_reg[g] <= 16'h0000;
               end_reg[g]   <= 16'h0000;
            end else if (take) begin
               begin_reg[g] <= clamp(LVL_BEGIN_DELAY, rd_max);
               end_reg[g]   <= clamp(LVL_END_DELAY, rd_max);
            end
         end

         // Carry kept in bit 16 so the halving loses nothing but the LSB
         assign sum    = {1'b0, begin_reg[g]} + {1'b0, end_reg[g]};
         assign mid[g] = hw_lvl ? sum[16:1] : rdly[g];

         // Capture point wraps at 16 bits; software keeps it in range
         always_ff @(posedge REF_CLK or negedge RESET_N) begin
            if (!RESET_N) begin
               cap_reg[g] <= 16'h0000;
            end else begin
               cap_reg[g] <= 16'(mid[g] + offs[g]);
            end
         end
         assign RD_CAPTURE_DELAY[16*g +: 16] = cap_reg[g];
      end
   endgenerate

   // ---------------------------------------------------------------------
   // Read-only rows and read mux
   // ---------------------------------------------------------------------
   assign read_center_groups_1_to_4 = {mid[4], mid[3], mid[2], mid[1]};
   assign read_center_groups_5_to_8 = {mid[8], mid[7], mid[6], mid[5]};
   assign view[dlr_pkg::V_MID_1_4]  = read_center_groups_1_to_4;
   assign view[dlr_pkg::V_MID_5_8]  = read_center_groups_5_to_8;
   assign view[dlr_pkg::V_END_0_3] = {end_reg[3], end_reg[2],
                                      end_reg[1], end_reg[0]};
   assign view[dlr_pkg::V_END_4_7] = {end_reg[7], end_reg[6],
                                      end_reg[5], end_reg[4]};
   assign view[dlr_pkg::V_END_8]   = {48'h0000_0000_0000, end_reg[8]};

   // Unmapped addresses read zero
   always_comb begin
      rd_word = 32'h0000_0000;
      for (int i = 0; i < dlr_pkg::N_VIEW; i++) begin
         if (hit(addr_reg, dlr_pkg::VIEW_OFF[i])) begin
            rd_word = addr_reg[2] ? view[i][63:32] : view[i][31:0];
         end
      end
   end

endmodule : dlr_leveling_regs

// [bench/dlr_leveling_regs_chk.sv]
/* Checker for the leveling delay register bank, bound to its ports.
   Assumes a single AHB-Lite master and REF_CLK as the only clock. */
`timescale 1ns/1ps
module dlr_leveling_regs_chk (
   input wire logic          REF_CLK,
   input wire logic          RESET_N,
   input wire logic          HSEL,
   input wire logic [1:0]    HTRANS,
   input wire logic          HWRITE,
   input wire logic          HREADY,
   input wire logic          HREADYOUT,
   input wire logic          HRESP,
   input wire logic          LVL_RESULT_STB,
   input wire logic [143:0]  GATE_DELAY,
   input wire logic [143:0]  RD_CAPTURE_DELAY,
   input wire logic [143:0]  WR_DQS_DELAY,
   input wire logic [15:0]   GATE_MAX_DELAY,
   input wire logic [15:0]   RDLVL_MAX_DELAY,
   input wire logic          RDLVL_HW_ENABLE
);
   default clocking dc @(posedge REF_CLK);
   endclocking
   default disable iff (!RESET_N);
   logic take_rd;
   logic take_wr;
   logic wr_dp_reg;
   assign take_rd = HSEL && HREADY && HTRANS == dlr_pkg::HTRANS_NONSEQ
                    && !HWRITE;
   assign take_wr = HSEL && HREADY && HTRANS == dlr_pkg::HTRANS_NONSEQ
                    && HWRITE;
   // Write data phase marker: settings other than the capture delay may only move after one
   always_ff @(posedge REF_CLK or negedge RESET_N) begin
      if (!RESET_N)
         wr_dp_reg <= 1'b0;
      else
         wr_dp_reg <= take_wr;
   end
   okay_resp_a: assert property (HRESP == dlr_pkg::HRESP_OKAY)
      else $error("response not OKAY");
   read_wait_a: assert property (take_rd |=> !HREADYOUT ##1 HREADYOUT)
      else $error("read wait state wrong");
   write_nowait_a: assert property (take_wr |=> HREADYOUT)
      else $error("write stalled");
   wait_cause_a: assert property (!HREADYOUT |-> $past(take_rd))
      else $error("wait state without read");
   limit_hold_a: assert property (
      !$stable({GATE_MAX_DELAY, RDLVL_MAX_DELAY, RDLVL_HW_ENABLE})
      |-> $past(wr_dp_reg))
      else $error("limit moved without write");
   gate_hold_a: assert property (
      !$stable(GATE_DELAY) |-> $past(wr_dp_reg))
      else $error("gate delay moved without write");
   wrdqs_hold_a: assert property (
      !$stable(WR_DQS_DELAY) |-> $past(wr_dp_reg))
      else $error("strobe delay moved without write");
   capture_cause_a: assert property (!$stable(RD_CAPTURE_DELAY) |->
      $past(wr_dp_reg, 2) || $past(LVL_RESULT_STB, 2))
      else $error("capture delay moved without cause");
   reset_zero_a: assert property ($rose(RESET_N) |-> GATE_DELAY == '0
      && WR_DQS_DELAY == '0 && RD_CAPTURE_DELAY == '0 && !RDLVL_HW_ENABLE)
      else $error("settings not zero after reset");
endmodule : dlr_leveling_regs_chk

bind dlr_leveling_regs dlr_leveling_regs_chk u_dlr_leveling_regs_chk (
   .REF_CLK(REF_CLK), .RESET_N(RESET_N), .HSEL(HSEL), .HTRANS(HTRANS),
   .HWRITE(HWRITE), .HREADY(HREADY), .HREADYOUT(HREADYOUT), .HRESP(HRESP),
   .LVL_RESULT_STB(LVL_RESULT_STB), .GATE_DELAY(GATE_DELAY),
   .RD_CAPTURE_DELAY(RD_CAPTURE_DELAY), .WR_DQS_DELAY(WR_DQS_DELAY),
   .GATE_MAX_DELAY(GATE_MAX_DELAY), .RDLVL_MAX_DELAY(RDLVL_MAX_DELAY),
   .RDLVL_HW_ENABLE(RDLVL_HW_ENABLE));

// [bench/dlr_lvl_engine.sv]
/* Leveling engine model: reports one group's window with a strobe.
   Assumes report is called from the bench's main process. */
`timescale 1ns/1ps
module dlr_lvl_engine (
   input  wire logic    REF_CLK,
   output logic         LVL_RESULT_STB,
   output logic [3:0]   LVL_RESULT_GROUP,
   output logic [15:0]  LVL_BEGIN_DELAY,
   output logic [15:0]  LVL_END_DELAY
);
   initial begin
      LVL_RESULT_STB = 1'b0;
      LVL_RESULT_GROUP = 4'h0;
      LVL_BEGIN_DELAY = 16'h5a5a;
      LVL_END_DELAY = 16'ha5a5;
   end
   task report(input logic [3:0]  g,
               input logic [15:0] b,
               input logic [15:0] e);
      @(posedge REF_CLK);
      LVL_RESULT_STB <= 1'b1;
      LVL_RESULT_GROUP <= g;
      LVL_BEGIN_DELAY <= b;
      LVL_END_DELAY <= e;
      @(posedge REF_CLK);
      LVL_RESULT_STB <= 1'b0;
      // Window lines are not held after the strobe
      LVL_BEGIN_DELAY <= ~b;
      LVL_END_DELAY <= ~e;
   endtask : report
endmodule : dlr_lvl_engine

// [bench/test_dlr_leveling_regs.sv]
/* Self-checking bench for the leveling delay register bank.
   Assumes the checker is bound and the engine model drives results. */
`timescale 1ns/1ps
module test_dlr_leveling_regs;
   logic REF_CLK, RESET_N, HSEL, HWRITE;
   logic [31:0] HADDR, HWDATA, q;
   logic [1:0] HTRANS;
   logic [2:0] HSIZE;
   wire logic HREADYOUT, HRESP, STB, HWEN;
   wire logic [31:0] HRDATA;
   wire logic [3:0] GRP;
   wire logic [15:0] BEG, ENDD, GMAX, RMAX, GREF, RREF, WREF;
   wire logic [143:0] GATE, CAP, WDQS;
   int n_errors, num_checks;
   dlr_leveling_regs u_dlr_leveling_regs (.REF_CLK(REF_CLK),
      .RESET_N(RESET_N), .HSEL(HSEL), .HADDR(HADDR), .HTRANS(HTRANS),
      .HWRITE(HWRITE), .HSIZE(HSIZE), .HWDATA(HWDATA), .HREADY(HREADYOUT),
      .HREADYOUT(HREADYOUT), .HRDATA(HRDATA), .HRESP(HRESP),
      .LVL_RESULT_STB(STB), .LVL_RESULT_GROUP(GRP), .LVL_BEGIN_DELAY(BEG),
      .LVL_END_DELAY(ENDD), .GATE_DELAY(GATE), .RD_CAPTURE_DELAY(CAP),
      .WR_DQS_DELAY(WDQS), .GATE_MAX_DELAY(GMAX), .RDLVL_MAX_DELAY(RMAX),
      .GATE_REFRESH_INTERVAL(GREF), .RDLVL_REFRESH_INTERVAL(RREF),
      .WRLVL_REFRESH_INTERVAL(WREF), .RDLVL_HW_ENABLE(HWEN));
   dlr_lvl_engine u_dlr_lvl_engine (.REF_CLK(REF_CLK), .LVL_RESULT_STB(STB),
      .LVL_RESULT_GROUP(GRP), .LVL_BEGIN_DELAY(BEG), .LVL_END_DELAY(ENDD));
   always #20 REF_CLK = ~REF_CLK;
   task end_sim;
      $display("checks %0d mismatches %0d", num_checks, n_errors);
      if (n_errors == 0 && num_checks > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask : end_sim
   task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      num_checks++;
      if (got !== exp) begin
         n_errors++;
         $display("[FAIL] %s expected %h seen %h", what, exp, got);
      end
   endtask : chk
   // Ready and read data are taken at the rising edge that ends the phase
   task wait_rdy;
      @(posedge REF_CLK);
      while (HREADYOUT !== 1'b1) begin
         @(posedge REF_CLK);
      end
      q = HRDATA;
   endtask : wait_rdy
   task xfer(input logic w, input logic [31:0] a, input logic [31:0] d);
      @(posedge REF_CLK);
      HSEL <= 1'b1;
      HTRANS <= dlr_pkg::HTRANS_NONSEQ;
      HADDR <= a;
      HWRITE <= w;
      wait_rdy();
      HTRANS <= 2'h0;
      HWDATA <= d;
      wait_rdy();
   endtask : xfer
   task rd_chk(input logic [31:0] a, input logic [31:0] exp);
      xfer(1'b0, a, 32'h0000_0000);
      chk($sformatf("read %h", a), exp, q);
   endtask : rd_chk
   task t_reset;
      logic [31:0] offs [7];
      offs = '{32'h0000_0a90, 32'h0000_0aa0, 32'h0000_0ab0, 32'h0000_0ac0,
               32'h0000_0ad0, 32'h0000_0ae0, 32'h0000_0af0};
      foreach (offs[i]) begin
         rd_chk(offs[i], 32'h0000_0000);
         rd_chk(offs[i] + 4, 32'h0000_0000);
      end
      $display("test reset done");
   endtask : t_reset
   task t_limits;
      xfer(1'b1, 32'h0000_0aa0, 32'h1234_5678);
      xfer(1'b1, 32'h0000_0aa4, 32'hffff_abcd);
      repeat (2) @(negedge REF_CLK);
      chk("gate max", 32'h0000_5678, {16'h0000, GMAX});
      chk("gate refresh", 32'h0000_1234, {16'h0000, GREF});
      chk("read max", 32'h0000_abcd, {16'h0000, RMAX});
      rd_chk(32'h0000_0aa4, 32'h0000_abcd);
      $display("test limits done");
   endtask : t_limits
   task t_gate;
      xfer(1'b1, 32'h0000_0a90, 32'h0002_0001);
      xfer(1'b1, 32'h0000_0a94, 32'h0004_0003);
      repeat (2) @(negedge REF_CLK);
      for (int g = 5; g < 9; g++)
         chk($sformatf("gate %0d", g), 32'(g - 4),
             {16'h0000, GATE[16*g +: 16]});
      rd_chk(32'h0000_0a94, 32'h0004_0003);
      $display("test gate done");
   endtask : t_gate
   task t_center;
      xfer(1'b1, 32'h0000_0c20, 32'h0020_0010);
      xfer(1'b1, 32'h0000_0ad0, 32'h0002_0001);
      xfer(1'b1, 32'h0000_0ab0, 32'hffff_ffff);
      repeat (3) @(negedge REF_CLK);
      chk("capture 0", 32'h0000_0011, {16'h0000, CAP[15:0]});
      chk("capture 1", 32'h0000_0022, {16'h0000, CAP[31:16]});
      rd_chk(32'h0000_0aa4, 32'h0010_abcd);
      rd_chk(32'h0000_0ab0, 32'h0000_0020);
      $display("test center done");
   endtask : t_center
   task t_hwlvl;
      xfer(1'b1, 32'h0000_0c50, 32'h0000_0001);
      u_dlr_lvl_engine.report(4'h1, 16'h0003, 16'h0008);
      u_dlr_lvl_engine.report(4'h9, 16'h0001, 16'h0001);
      repeat (3) @(negedge REF_CLK);
      chk("capture 1 hw", 32'h0000_0007, {16'h0000, CAP[31:16]});
      chk("hw enable", 32'h0000_0001, {31'h0000_0000, HWEN});
      rd_chk(32'h0000_0ab0, 32'h0000_0005);
      rd_chk(32'h0000_0c60, 32'h0008_0000);
      rd_chk(32'h0000_0c80, 32'h0000_0000);
      $display("test hw leveling done");
   endtask : t_hwlvl
   task t_wrdqs;
      xfer(1'b1, 32'h0000_0af0, 32'h0007_0003);
      xfer(1'b1, 32'h0000_0af4, 32'h2222_1111);
      xfer(1'b1, 32'h0000_0b14, 32'h0009_0005);
      repeat (2) @(negedge REF_CLK);
      chk("strobe 8", 32'h0000_0005, {16'h0000, WDQS[143:128]});
      chk("write refresh", 32'h0000_0009, {16'h0000, WREF});
      chk("capture 8", 32'h0000_0003, {16'h0000, CAP[143:128]});
      chk("strobe 0", 32'h0000_1111, {16'h0000, WDQS[15:0]});
      chk("strobe 1", 32'h0000_2222, {16'h0000, WDQS[31:16]});
      chk("read refresh", 32'h0000_0007, {16'h0000, RREF});
      rd_chk(32'h0000_0aa8, 32'h0000_0000);
      rd_chk(32'h0000_0af4, 32'h2222_1111);
      $display("test write strobe done");
   endtask : t_wrdqs
   initial begin
      REF_CLK = 1'b0;
      RESET_N = 1'b0;
      HSEL = 1'b0;
      HADDR = 32'h0000_0000;
      HTRANS = 2'h0;
      HWRITE = 1'b0;
      HSIZE = 3'h2;
      HWDATA = 32'h0000_0000;
      n_errors = 0;
      num_checks = 0;
      repeat (2) @(posedge REF_CLK);
      RESET_N <= 1'b1;
      t_reset();
      t_limits();
      t_gate();
      t_center();
      t_hwlvl();
      t_wrdqs();
      end_sim();
   end
   initial begin
      repeat (3000) @(posedge REF_CLK);
      n_errors++;
      end_sim();
   end
endmodule : test_dlr_leveling_regs
